// ### bench/fwqs_storage_model.sv
// fwqs_storage_model.sv: data storage side taking store beats from the store unit
// assumes beats are offered on store_valid and taken at an edge with store_ready high
`timescale 1ns/1ps

module fwqs_storage_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic store_valid,
    input fwqs_pkg::fwqs_store_t store_beat,
    output logic store_ready,
    output int unsigned acc_cnt,
    output fwqs_pkg::fwqs_store_t acc_log [4]
);
    // --------------------------------------------------------------
    // acceptance
    // --------------------------------------------------------------
    // slow mode stalls every other cycle so a beat must stand across a refusal
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            store_ready <= 1'b0;
            acc_cnt <= 0;
        end else begin
            store_ready <= slow ? ~store_ready : 1'b1;
            if (store_valid && store_ready) begin
                acc_log[acc_cnt[1:0]] <= store_beat;
                acc_cnt <= acc_cnt + 1;
            end
        end
    end
endmodule : fwqs_storage_model

// ### bench/tb_fp_word_quad_store_decode.sv
// tb_fp_word_quad_store_decode.sv: self-checking bench for the fp word/quad store unit
// assumes register files answer in the same cycle and one storage model stands on the far side
`timescale 1ns/1ps

module tb_fp_word_quad_store_decode;
    logic mclk = 1'b0;
    logic rstn, clk_en, insn_valid, slow, side_bad;
    logic [31:0] insn;
    logic insn_ready, insn_unknown, store_valid, store_ready, gpr_wb_valid, fpscr_we, cr0_we;
    logic [4:0] gpr_rd_a, gpr_rd_b, fpr_rd;
    fwqs_pkg::fwqs_store_t store_beat, acc_log [4];
    fwqs_pkg::fwqs_gpr_wb_t gpr_wb, wb_last;
    int unsigned acc_cnt;
    int mismatches, comparisons, wb_cnt, unk_cnt;
    logic [31:0] gpr [32];
    logic [63:0] fpr [32];
    logic single [32];

    `define check(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
        $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

    always #2.5 mclk = ~mclk;

    fwqs_store_unit dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .insn_valid(insn_valid),
        .insn(insn), .insn_ready(insn_ready), .insn_unknown(insn_unknown),
        .gpr_rd_a(gpr_rd_a), .gpr_rd_b(gpr_rd_b), .gpr_data_a(gpr[gpr_rd_a]),
        .gpr_data_b(gpr[gpr_rd_b]), .fpr_rd(fpr_rd), .fpr_data(fpr[fpr_rd]),
        .fpr_single_tag(single[fpr_rd]), .store_valid(store_valid), .store_beat(store_beat),
        .store_ready(store_ready), .gpr_wb_valid(gpr_wb_valid), .gpr_wb(gpr_wb),
        .fpscr_we(fpscr_we), .cr0_we(cr0_we));

    fwqs_storage_model stor (.mclk(mclk), .rstn(rstn), .slow(slow), .store_valid(store_valid),
        .store_beat(store_beat), .store_ready(store_ready), .acc_cnt(acc_cnt),
        .acc_log(acc_log));

    // --------------------------------------------------------------
    // monitors
    // --------------------------------------------------------------
    // sampled on the falling edge, away from the launching edge
    always @(negedge mclk) begin
        if (gpr_wb_valid === 1'b1) begin
            wb_cnt++;
            wb_last = gpr_wb;
        end
        if (insn_unknown === 1'b1) unk_cnt++;
        if (fpscr_we !== 1'b0 || cr0_we !== 1'b0) side_bad = 1'b1;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    function automatic logic [31:0] xf(input logic [9:0] xo, input logic [4:0] s, a, b,
        input logic rc);
        return {6'h1f, s, a, b, xo, rc};
    endfunction : xf

    function automatic logic [31:0] df(input logic [5:0] op, input logic [4:0] s, a,
        input logic [13:0] ds, input logic [1:0] sub);
        return {op, s, a, ds, sub};
    endfunction : df

    task automatic wait_until(input logic [31:0] w, input int unsigned want);
        int n;
        n = 0;
        while (!(insn_ready === 1'b1 && acc_cnt == want) && n < 60) begin
            @(negedge mclk);
            n++;
        end
        if (n == 60) begin
            mismatches++;
            $display("Error at %0t: no completion for %h", $time, w);
            test_done();
        end
    endtask : wait_until

    // request held from a falling edge through the taking rising edge
    task automatic do_insn(input logic [31:0] w, input int unsigned nb);
        int unsigned c0;
        c0 = acc_cnt;
        wait_until(w, c0);
        insn = w;
        insn_valid = 1'b1;
        @(negedge mclk);
        insn_valid = 1'b0;
        wait_until(w, c0 + nb);
        repeat (2) @(negedge mclk);
    endtask : do_insn

    task automatic run(input logic [31:0] w, input int nb, input logic [31:0] ea,
        input logic [4:0] s, input logic un, input int wbn);
        int unsigned c0;
        int w0;
        logic [4:0] s2;
        c0 = acc_cnt;
        w0 = wb_cnt;
        s2 = s + 5'h01;
        do_insn(w, nb);
        if (nb == 1) begin
            `check(acc_log[c0[1:0]], {ea, 32'h0, fpr[s][31:0], 8'h0f, un})
        end else begin
            `check(acc_log[c0[1:0]], {ea, fpr[s], 8'hff, 1'b0})
            `check(acc_log[2'(c0 + 1)], {ea + 32'h8, fpr[s2], 8'hff, 1'b0})
        end
        `check(wb_cnt - w0, wbn)
        if (wbn == 1) `check(wb_last, {w[20:16], ea})
    endtask : run

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_word();
        run(xf(10'h3d7, 5'h05, 5'h04, 5'h06, 1'b1), 1, 32'h0000_1008, 5'h05, 1'b0, 0);
        single[5] = 1'b1;
        run(xf(10'h3d7, 5'h05, 5'h00, 5'h06, 1'b1), 1, 32'h0000_0008, 5'h05, 1'b1, 0);
        single[5] = 1'b0;
    endtask : t_word

    task automatic t_quad_d();
        run(df(6'h3c, 5'h1f, 5'h04, 14'h3ffe, 2'h0), 2, 32'h0000_0ff8, 5'h1f, 1'b0, 0);
        run(df(6'h3c, 5'h03, 5'h00, 14'h1fff, 2'h0), 2, 32'h0000_7ffc, 5'h03, 1'b0, 0);
    endtask : t_quad_d

    task automatic t_quad_du();
        slow = 1'b1;
        run(df(6'h3d, 5'h07, 5'h09, 14'h0004, 2'h1), 2, 32'h2000_0010, 5'h07, 1'b0, 1);
        run(df(6'h3d, 5'h08, 5'h00, 14'h2000, 2'h1), 2, 32'hffff_8000, 5'h08, 1'b0, 0);
        slow = 1'b0;
    endtask : t_quad_du

    task automatic t_quad_x();
        run(xf(10'h397, 5'h1e, 5'h04, 5'h06, 1'b0), 2, 32'h0000_1008, 5'h1e, 1'b0, 0);
        run(xf(10'h397, 5'h01, 5'h00, 5'h06, 1'b1), 2, 32'h0000_0008, 5'h01, 1'b0, 0);
    endtask : t_quad_x

    task automatic t_quad_xu();
        run(xf(10'h3b7, 5'h02, 5'h00, 5'h06, 1'b1), 2, 32'h0000_0008, 5'h02, 1'b0, 0);
        run(xf(10'h3b7, 5'h1f, 5'h04, 5'h06, 1'b0), 2, 32'h0000_1008, 5'h1f, 1'b0, 1);
    endtask : t_quad_xu

    // near misses of the opcode table: wrong sub field, an excluded extended opcode
    task automatic t_unknown();
        int u0;
        int unsigned c0;
        u0 = unk_cnt;
        c0 = acc_cnt;
        do_insn(df(6'h3c, 5'h01, 5'h04, 14'h0001, 2'h1), 0);
        do_insn(xf(10'h2d7, 5'h01, 5'h04, 5'h06, 1'b0), 0);
        `check(unk_cnt - u0, 2)
        `check(acc_cnt, c0)
    endtask : t_unknown

    // a frozen block takes nothing although a word is offered, then runs it
    task automatic t_freeze();
        int unsigned c0;
        logic [31:0] w;
        c0 = acc_cnt;
        w = df(6'h3c, 5'h02, 5'h04, 14'h0002, 2'h0);
        clk_en = 1'b0;
        insn = w;
        insn_valid = 1'b1;
        repeat (4) @(negedge mclk);
        `check(acc_cnt, c0)
        `check(insn_ready, 1'b1)
        clk_en = 1'b1;
        run(w, 2, 32'h0000_1008, 5'h02, 1'b0, 0);
    endtask : t_freeze

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        insn_valid = 1'b0;
        insn = 32'h0;
        slow = 1'b0;
        side_bad = 1'b0;
        mismatches = 0;
        comparisons = 0;
        wb_cnt = 0;
        unk_cnt = 0;
        for (int i = 0; i < 32; i++) begin
            gpr[i] = 32'h1111_0000 ^ 32'(i);
            fpr[i] = {32'ha5a5_0000 ^ 32'(i), 32'h0000_5a5a ^ 32'(i)};
            single[i] = 1'b0;
        end
        gpr[4] = 32'h0000_1000;
        gpr[6] = 32'h0000_0008;
        gpr[9] = 32'h2000_0000;
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        t_word();
        t_quad_d();
        t_quad_du();
        t_quad_x();
        t_quad_xu();
        t_unknown();
        t_freeze();
        `check(side_bad, 1'b0)
        test_done();
    end
endmodule : tb_fp_word_quad_store_decode

// ### core/fwqs_decode.sv
// fwqs_decode.sv: combinational decode of the fp word and quad store forms
// assumes a 32-bit instruction word presented with its valid strobe
`timescale 1ns/1ps
`include "fwqs_defines.svh"

module fwqs_decode (
    input wire logic [31:0] insn,
    output fwqs_pkg::fwqs_kind_t kind,
    output logic [4:0] src_fpr,
    output logic [4:0] base_gpr,
    output logic [4:0] index_gpr,
    output logic [31:0] disp_offset,
    output logic record_bit
);
    wire [5:0] opcd = insn[`FWQS_F_OPCD];
    wire [9:0] xo = insn[`FWQS_F_XO];
    wire [1:0] sub = insn[`FWQS_F_SUB];
    wire [13:0] displacement_field = insn[`FWQS_F_DISP];
    wire is_ext = (opcd == `FWQS_OP_EXT);
    wire is_qd = (opcd == `FWQS_OP_QSTORE_D) && (sub == `FWQS_SUB_D);
    wire is_qdu = (opcd == `FWQS_OP_QSTORE_DU) && (sub == `FWQS_SUB_DU);
    wire is_qxu = is_ext && (xo == `FWQS_XO_QSTORE_XU);
    wire is_qx = is_ext && (xo == `FWQS_XO_QSTORE_X);
    wire is_wx = is_ext && (xo == `FWQS_XO_WSTORE_X);

    assign kind = is_qd ? fwqs_pkg::FWQS_QUAD_D :
                  is_qdu ? fwqs_pkg::FWQS_QUAD_DU :
                  is_qxu ? fwqs_pkg::FWQS_QUAD_XU :
                  is_qx ? fwqs_pkg::FWQS_QUAD_X :
                  is_wx ? fwqs_pkg::FWQS_WORD_X : fwqs_pkg::FWQS_NONE;
    assign src_fpr = insn[`FWQS_F_SRC];
    assign base_gpr = insn[`FWQS_F_BASE];
    assign index_gpr = insn[`FWQS_F_INDEX];
    assign record_bit = insn[`FWQS_F_REC];
    // sign-extend to 30 bits, then two zero bits on the right
    assign disp_offset = {{`FWQS_DISP_EXT{displacement_field[`FWQS_DISP_SIGN]}},
                          displacement_field, 2'h0};
endmodule : fwqs_decode

// ### core/fwqs_store_unit.sv
// fwqs_store_unit.sv: issue logic for fp integer-word and quad stores
// assumes register files answer reads in the same cycle, and the storage
// side accepts a beat when store_ready is high
// Behaviour
// - word store writes low 32 bits unconverted
// - indexed address: base plus index, or index
// - single-precision source may store undefined word
// - fp status and cr0 never modified
// - opcode 60 sub 00 is quad store
// - opcode 61 sub 01 is quad update
// - 31/951 indexed quad update; record bit
// - 31/919 indexed quad; base/index fields
// - two doublewords: source, next, wrap at 31
// - update forms write address to nonzero base
// - 31/983 is integer-word store
`timescale 1ns/1ps
`include "fwqs_defines.svh"

module fwqs_store_unit (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic insn_valid,
    input wire logic [31:0] insn,
    output logic insn_ready,
    output logic insn_unknown,
    output logic [4:0] gpr_rd_a,
    output logic [4:0] gpr_rd_b,
    input wire logic [31:0] gpr_data_a,
    input wire logic [31:0] gpr_data_b,
    output logic [4:0] fpr_rd,
    input wire logic [63:0] fpr_data,
    input wire logic fpr_single_tag,
    output logic store_valid,
    output fwqs_pkg::fwqs_store_t store_beat,
    input wire logic store_ready,
    output logic gpr_wb_valid,
    output fwqs_pkg::fwqs_gpr_wb_t gpr_wb,
    output logic fpscr_we,
    output logic cr0_we
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rst_n = rst_sync_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    fwqs_pkg::fwqs_kind_t dec_kind;
    logic [4:0] dec_src;
    logic [4:0] dec_base;
    logic [4:0] dec_index;
    logic [31:0] dec_off;
    logic dec_rec;

    fwqs_decode u_decode (
        .insn(insn),
        .kind(dec_kind),
        .src_fpr(dec_src),
        .base_gpr(dec_base),
        .index_gpr(dec_index),
        .disp_offset(dec_off),
        .record_bit(dec_rec)
    );

    // ------------------------------------------------------------
    // held instruction and state
    // ------------------------------------------------------------
    fwqs_pkg::fwqs_state_t state_reg;
    fwqs_pkg::fwqs_state_t state_next;
    fwqs_pkg::fwqs_kind_t kind_reg;
    logic [4:0] src_reg;
    logic [4:0] base_reg;
    logic [31:0] ea_reg;
    logic insn_ready_reg;

    wire idle = (state_reg == fwqs_pkg::FWQS_IDLE);
    wire take = idle && insn_valid && insn_ready_reg;
    wire known = (dec_kind != fwqs_pkg::FWQS_NONE);
    wire is_disp = (dec_kind == fwqs_pkg::FWQS_QUAD_D) || (dec_kind == fwqs_pkg::FWQS_QUAD_DU);
    wire base_zero = (dec_base == `FWQS_GPR_ZERO);

    // register file read ports addressed straight from the fetched word;
    // the read is combinational so the address is sampled in the take cycle
    assign gpr_rd_a = dec_base;
    assign gpr_rd_b = dec_index;

    wire [31:0] base_term = base_zero ? 32'h0000_0000 : gpr_data_a;
    wire [31:0] idx_term = is_disp ? dec_off : gpr_data_b;
    wire [31:0] ea_calc = base_term + idx_term;

    wire is_quad_held = (kind_reg != fwqs_pkg::FWQS_WORD_X);
    wire is_upd_held = (kind_reg == fwqs_pkg::FWQS_QUAD_DU) ||
                       (kind_reg == fwqs_pkg::FWQS_QUAD_XU);
    wire [4:0] next_fpr = src_reg + 5'h01; // wraps 31 to 0 by width
    wire beat_done = store_valid && store_ready;
    // limitation: keep clk_en high while a beat is offered; the storage side
    // sees no enable, so a frozen beat that it accepts would be sent twice

    // fpr read follows the beat being issued
    wire [4:0] fpr_sel = (state_next == fwqs_pkg::FWQS_SECOND) ? next_fpr : src_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fwqs_pkg::FWQS_IDLE: begin
                if (take && known) begin
                    state_next = fwqs_pkg::FWQS_FIRST;
                end
            end
            fwqs_pkg::FWQS_FIRST: begin
                if (beat_done) begin
                    state_next = is_quad_held ? fwqs_pkg::FWQS_SECOND : fwqs_pkg::FWQS_IDLE;
                end
            end
            fwqs_pkg::FWQS_SECOND: begin
                if (beat_done) begin
                    state_next = fwqs_pkg::FWQS_IDLE;
                end
            end
            default: begin
                state_next = fwqs_pkg::FWQS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // beat formation
    // ------------------------------------------------------------
    // the fp register is read in the cycle the beat is loaded, so the
    // source data are captured one cycle after the held instruction
    logic load_first;
    logic load_second;
    assign load_first = (state_reg == fwqs_pkg::FWQS_FIRST) && !store_valid;
    assign load_second = (state_reg == fwqs_pkg::FWQS_FIRST) && beat_done && is_quad_held;
    fwqs_pkg::fwqs_store_t beat_next;
    always_comb begin
        beat_next = store_beat;
        if (load_first) begin
            beat_next.addr = ea_reg;
            if (kind_reg == fwqs_pkg::FWQS_WORD_X) begin
                beat_next.data = {32'h0000_0000, fpr_data[`FWQS_LOW_WORD]};
                beat_next.byte_en = 8'h0f;
                beat_next.undef = fpr_single_tag;
            end else begin
                beat_next.data = fpr_data;
                beat_next.byte_en = 8'hff;
                beat_next.undef = 1'b0;
            end
        end else if (load_second) begin
            beat_next.addr = ea_reg + `FWQS_DW_STEP;
            beat_next.data = fpr_data;
            beat_next.byte_en = 8'hff;
            beat_next.undef = 1'b0;
        end
    end
    assign fpr_rd = load_second ? next_fpr : fpr_sel;

    logic valid_next;
    assign valid_next = load_first || load_second ||
                        (store_valid && !store_ready);

    // write-back once the final beat is accepted; only update forms,
    // only with a nonzero base
    wire last_done = beat_done && (state_next == fwqs_pkg::FWQS_IDLE);
    wire wb_fire = last_done && is_upd_held && (base_reg != `FWQS_GPR_ZERO);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fwqs_pkg::FWQS_IDLE;
            kind_reg <= fwqs_pkg::FWQS_NONE;
            src_reg <= 5'h00;
            base_reg <= 5'h00;
            ea_reg <= 32'h0000_0000;
            insn_ready_reg <= 1'b0;
            insn_unknown <= 1'b0;
            store_valid <= 1'b0;
            store_beat <= '0;
            gpr_wb_valid <= 1'b0;
            gpr_wb <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            insn_ready_reg <= (state_next == fwqs_pkg::FWQS_IDLE) && !(take && known);
            insn_unknown <= take && !known;
            if (take && known) begin
                kind_reg <= dec_kind;
                src_reg <= dec_src;
                base_reg <= dec_base;
                ea_reg <= ea_calc;
            end
            store_valid <= valid_next;
            store_beat <= beat_next;
            gpr_wb_valid <= wb_fire;
            if (wb_fire) begin
                gpr_wb.gpr <= base_reg;
                gpr_wb.value <= ea_reg;
            end
        end
    end

    assign insn_ready = insn_ready_reg;
    // no path to the fp status register or cr field 0, record bit or not
    assign fpscr_we = 1'b0;
    assign cr0_we = 1'b0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_second_addr_step: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && load_second) |=> (store_beat.addr == $past(store_beat.addr) + 32'h8))
        else $error("second doubleword not eight bytes above first");
    a_wrap_fpr: assert property (@(posedge mclk) disable iff (!rst_n)
        (load_second && src_reg == 5'h1f) |-> (fpr_rd == 5'h00))
        else $error("fpr number did not wrap to zero");
    a_word_low_half: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && load_first && kind_reg == fwqs_pkg::FWQS_WORD_X)
        |=> (store_beat.byte_en == 8'h0f && store_beat.data[31:0] == $past(fpr_data[31:0])))
        else $error("word store data not low fpr word");
    a_index_only_ea: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && take && known && !is_disp && base_zero) |=> (ea_reg == $past(gpr_data_b)))
        else $error("zero base did not select index alone");
    a_indexed_sum: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && take && known && !is_disp && !base_zero)
        |=> (ea_reg == $past(gpr_data_a) + $past(gpr_data_b)))
        else $error("indexed address not base plus index");
    a_disp_offset: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && take && is_disp)
        |=> (ea_reg == $past(base_term) + {{16{$past(insn[15])}}, $past(insn[15:2]), 2'h0}))
        else $error("displacement address wrong");
    a_no_status_write: assert property (@(posedge mclk) disable iff (!rst_n)
        !(fpscr_we || cr0_we))
        else $error("status or cr0 written");
    a_update_writes_base: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && wb_fire) |=> (gpr_wb_valid && gpr_wb.value == $past(ea_reg)
                                 && gpr_wb.gpr != 5'h00))
        else $error("update form did not write base");
    a_nonupdate_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && last_done && !is_upd_held) |=> !gpr_wb_valid)
        else $error("non-update form wrote base");
    a_decode_opc60: assert property (@(posedge mclk) disable iff (!rst_n)
        (insn[31:26] == 6'h3c && insn[1:0] == 2'h0) |-> (dec_kind == fwqs_pkg::FWQS_QUAD_D))
        else $error("opcode 60 not decoded as quad store");
    a_decode_opc61: assert property (@(posedge mclk) disable iff (!rst_n)
        (insn[31:26] == 6'h3d && insn[1:0] == 2'h1) |-> (dec_kind == fwqs_pkg::FWQS_QUAD_DU))
        else $error("opcode 61 not decoded as quad update");
    a_decode_ext: assert property (@(posedge mclk) disable iff (!rst_n)
        (insn[31:26] == 6'h1f && (insn[10:1] == 10'h3b7 || insn[10:1] == 10'h397
                                  || insn[10:1] == 10'h3d7)) |-> known)
        else $error("indexed store form not decoded");
    a_undef_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && load_first && kind_reg != fwqs_pkg::FWQS_WORD_X) |=> !store_beat.undef)
        else $error("quad beat flagged undefined");
    a_beat_holds: assert property (@(posedge mclk) disable iff (!rst_n)
        (store_valid && !store_ready) |=> (store_valid && store_beat == $past(store_beat)))
        else $error("offered beat changed before acceptance");
    a_quad_first_beat: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && load_first && kind_reg != fwqs_pkg::FWQS_WORD_X)
        |=> (store_beat.addr == $past(ea_reg) && store_beat.data == $past(fpr_data)
             && store_beat.byte_en == 8'hff))
        else $error("first quad beat wrong");
    a_quad_second_data: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && load_second)
        |=> (store_beat.data == $past(fpr_data) && store_beat.byte_en == 8'hff))
        else $error("second quad beat data wrong");
    a_word_undef_tag: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && load_first && kind_reg == fwqs_pkg::FWQS_WORD_X)
        |=> (store_beat.undef == $past(fpr_single_tag)))
        else $error("word store undefined flag wrong");
    a_record_no_cr0: assert property (@(posedge mclk) disable iff (!rst_n)
        (take && dec_rec) |-> !(cr0_we || fpscr_we))
        else $error("record bit reached status or cr0");
    a_zero_base_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && last_done && base_reg == 5'h00) |=> !gpr_wb_valid)
        else $error("zero base register written back");
    a_wb_target_base: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && wb_fire) |=> (gpr_wb.gpr == $past(base_reg)))
        else $error("write-back to wrong register");
    a_word_one_beat: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && beat_done && state_reg == fwqs_pkg::FWQS_FIRST
         && kind_reg == fwqs_pkg::FWQS_WORD_X) |=> !store_valid)
        else $error("word store issued a second beat");
    a_unknown_dropped: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && take && !known)
        |=> (insn_unknown && !store_valid && state_reg == fwqs_pkg::FWQS_IDLE))
        else $error("unknown word not dropped");
    a_disp_zero_base: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && take && is_disp && base_zero)
        |=> (ea_reg == {{16{$past(insn[15])}}, $past(insn[15:2]), 2'h0}))
        else $error("zero base displacement address wrong");
endmodule : fwqs_store_unit

// ### shared/fwqs_defines.svh
// fwqs_defines.svh: opcodes, field positions and widths of the fp word/quad store decoder
// assumes instructions in big-endian bit numbering (bit 0 is the msb)
`ifndef FWQS_DEFINES_SVH
`define FWQS_DEFINES_SVH

`define FWQS_OP_QSTORE_D 6'h3c
`define FWQS_OP_QSTORE_DU 6'h3d
`define FWQS_OP_EXT 6'h1f
`define FWQS_XO_QSTORE_XU 10'h3b7
`define FWQS_XO_QSTORE_X 10'h397
`define FWQS_XO_WSTORE_X 10'h3d7
`define FWQS_SUB_D 2'h0
`define FWQS_SUB_DU 2'h1
`define FWQS_GPR_ZERO 5'h00
`define FWQS_FPR_LAST 5'h1f
`define FWQS_DW_STEP 32'h0000_0008
`define FWQS_LOW_WORD 31:0
// instruction fields, lsb-0 positions of the big-endian numbering
`define FWQS_F_OPCD 31:26
`define FWQS_F_SRC 25:21
`define FWQS_F_BASE 20:16
`define FWQS_F_INDEX 15:11
`define FWQS_F_DISP 15:2
`define FWQS_F_SUB 1:0
`define FWQS_F_XO 10:1
`define FWQS_F_REC 0
`define FWQS_DISP_SIGN 13
`define FWQS_DISP_EXT 16

`endif

// ### shared/fwqs_pkg.sv
// fwqs_pkg.sv: types shared by the decoder and its store-request issue logic
// assumes fwqs_defines.svh is included by the files that use the field macros
package fwqs_pkg;

    typedef enum logic [2:0] {
        FWQS_NONE = 3'h0,
        FWQS_WORD_X = 3'h1,
        FWQS_QUAD_D = 3'h2,
        FWQS_QUAD_DU = 3'h3,
        FWQS_QUAD_X = 3'h4,
        FWQS_QUAD_XU = 3'h5
    } fwqs_kind_t;

    typedef enum logic [1:0] {
        FWQS_IDLE = 2'h0,
        FWQS_FIRST = 2'h1,
        FWQS_SECOND = 2'h2
    } fwqs_state_t;

    // one store beat to the data storage subsystem
    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        logic [7:0] byte_en;
        logic undef;
    } fwqs_store_t;

    // base register write-back
    typedef struct packed {
        logic [4:0] gpr;
        logic [31:0] value;
    } fwqs_gpr_wb_t;

endpackage : fwqs_pkg
